/* File: design/ipf_prio_reg.sv */
// APB priority register with four 3-bit source priority fields
`include "ipf_map.svh"
`default_nettype none
// What this block does
// (R1) A field value of 7 gives its source the highest level, 7.
// (R2) A field value of 1 gives the lowest active level, codes map linearly.
// (R3) A field value of 0 disables its source so it never requests.
// (R4) The comparator field is read/write at bits 10-8.
// (R5) The I2C master event field is read/write at bits 6-4.
// (R6) Change notify sits at 14-12, slave at 2-0, gaps read 0, reset 100.
module ipf_prio_reg (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Interrupt sources and priority outputs
    input wire ipf_pkg::ipf_src_t src,
    output ipf_pkg::ipf_out_t prio
);
    import ipf_pkg::*;

    // =====================================================
    // Bus decode
    logic [15:0] reg_r;
    logic [15:0] reg_nxt;
    logic hit;
    logic wr_acc;
    ipf_phase_t phase_r;
    assign hit = (paddr[11:2] == 10'(`IPF_REG_OFFSET >> 2));
    assign wr_acc = psel && penable && pwrite && hit && (phase_r == IPF_ACC);
    assign pready = 1'b1;
    assign pslverr = psel && penable && !hit;

    // Phase tracker; a write counts only in an access after its setup
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            phase_r <= IPF_IDLE;
        end else begin
            case (phase_r)
                IPF_IDLE: begin
                    if (psel && !penable) begin
                        phase_r <= IPF_ACC;
                    end
                end
                IPF_ACC: begin
                    if (!(psel && !penable)) begin
                        phase_r <= IPF_IDLE;
                    end
                end
                default: begin
                    phase_r <= IPF_IDLE;
                end
            endcase
        end
    end

    // =====================================================
    // Register storage with byte strobes, gaps forced to zero
    always_comb begin
        reg_nxt = reg_r;
        if (wr_acc && pstrb[0]) begin
            reg_nxt[7:0] = pwdata[7:0];
        end
        if (wr_acc && pstrb[1]) begin
            reg_nxt[15:8] = pwdata[15:8];
        end
        reg_nxt = reg_nxt & `IPF_FIELD_MASK; // R6
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            reg_r <= {1'b0, `IPF_FIELD_RESET, 1'b0, `IPF_FIELD_RESET,
                      1'b0, `IPF_FIELD_RESET, 1'b0, `IPF_FIELD_RESET}; // R6
        end else begin
            reg_r <= reg_nxt; // R4 R5
        end
    end

    // Read word: the register in the low half, zero above and off the map
    logic [31:0] rd_word;
    always_comb begin
        rd_word = 32'h00000000;
        if (hit) begin
            rd_word = {16'h0000, reg_r}; // R6
        end
    end

    // Read data from a flip-flop, loaded in the setup cycle
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            prdata <= 32'h00000000;
        end else if (psel && !penable && !pwrite) begin
            prdata <= rd_word;
        end
    end

    // =====================================================
    // Per source level and gated request
    // Field positions, listed from change notify down to slave
    localparam int IPF_LSB [4] = '{`IPF_CN_LSB, `IPF_CMP_LSB,
                                   `IPF_MST_LSB, `IPF_SLV_LSB};
    // Per source nets, packed into the output struct in one place
    wire ipf_level_t [3:0] lvl_w;
    wire logic [3:0] irq_w;
    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_src
            // Field code is the level itself, linear from 1 to 7
            assign lvl_w[g] = reg_r[IPF_LSB[3-g] +: 3]; // R1 R2
            // Zero level blocks the request
            assign irq_w[g] = src.req[g] &&
                (lvl_w[g] != `IPF_LVL_OFF); // R3
        end
    endgenerate
    // Output struct gathered from the per source nets
    assign prio = '{irq: irq_w, level: lvl_w};

    // =====================================================
    // Checks
    // Bus phases seen at a rising edge, shared by multi-step checks
    sequence s_rd_hit;
        psel && !penable && !pwrite && hit;
    endsequence
    sequence s_rd_miss;
        psel && !penable && !pwrite && !hit;
    endsequence
    sequence s_wr_setup;
        psel && !penable && pwrite && hit;
    endsequence
    sequence s_wr_full;
        psel && penable && pwrite && hit && (pstrb[1:0] == 2'b11);
    endsequence

    // A zero code silences its source, a set code lets requests pass
    a_off_blocks: assert property (@(posedge sys_clk) disable iff (rst) // R3
        (prio.level[0] == 3'h0) |-> !prio.irq[0])
        else $error("disabled slave source requested");
    a_no_spurious: assert property (@(posedge sys_clk) disable iff (rst) // R3
        (prio.irq & ~src.req) == 4'h0)
        else $error("request raised with no source request");
    a_cmp_active: assert property (@(posedge sys_clk) disable iff (rst) // R2
        (prio.level[2] != 3'h0 && src.req[2]) |-> prio.irq[2])
        else $error("enabled comparator source blocked");
    // The same gate, source by source
    for (g = 0; g < 4; g++) begin : g_chk
        a_src_gate: assert property (@(posedge sys_clk) disable iff (rst) // R3
            (lvl_w[g] == 3'h0) |-> !irq_w[g])
            else $error("disabled source requested");
        a_src_pass: assert property (@(posedge sys_clk) disable iff (rst) // R2
            (lvl_w[g] != 3'h0 && src.req[g]) |-> irq_w[g])
            else $error("enabled source blocked");
    end

    // Level outputs follow the code linearly
    a_top_level: assert property (@(posedge sys_clk) disable iff (rst) // R1
        (reg_r[14:12] == 3'h7) |-> (prio.level[3] == 3'h7))
        else $error("code 7 not level 7");
    a_low_level: assert property (@(posedge sys_clk) disable iff (rst) // R2
        (reg_r[2:0] == 3'h1 && src.req[0]) |-> (prio.irq[0] &&
        prio.level[0] == 3'h1))
        else $error("code 1 not active level 1");

    // Writes land in the addressed field one edge after the access
    a_cmp_write: assert property (@(posedge sys_clk) disable iff (rst) // R4
        (wr_acc && pstrb[1]) |=> (reg_r[10:8] == $past(pwdata[10:8])))
        else $error("comparator field not written");
    a_mst_write: assert property (@(posedge sys_clk) disable iff (rst) // R5
        (wr_acc && pstrb[0]) |=> (prio.level[1] == $past(pwdata[6:4])))
        else $error("master field not written");
    a_cn_write: assert property (@(posedge sys_clk) disable iff (rst) // R6
        (wr_acc && pstrb[1]) |=> (prio.level[3] == $past(pwdata[14:12])))
        else $error("change notify field not written");
    a_slv_write: assert property (@(posedge sys_clk) disable iff (rst) // R6
        (wr_acc && pstrb[0]) |=> (prio.level[0] == $past(pwdata[2:0])))
        else $error("slave field not written");
    a_full_write: assert property (@(posedge sys_clk) disable iff (rst) // R6
        s_wr_setup ##1 s_wr_full |=>
        (reg_r == ($past(pwdata[15:0]) & `IPF_FIELD_MASK)))
        else $error("full word write not masked into register");

    // Only an accepted write moves the register
    a_hold_value: assert property (@(posedge sys_clk) disable iff (rst) // R4
        !wr_acc |=> $stable(reg_r))
        else $error("register changed without write");
    a_unmap_ignore: assert property (@(posedge sys_clk) disable iff (rst) // R6
        (psel && penable && pwrite && !hit) |=> $stable(reg_r))
        else $error("write to unmapped word changed register");
    a_gap_zero: assert property (@(posedge sys_clk) disable iff (rst) // R6
        (reg_r & ~`IPF_FIELD_MASK) == 16'h0000)
        else $error("unimplemented bit set");
    a_reset_val: assert property (@(posedge sys_clk) // R6
        rst |=> (reg_r == 16'h4444))
        else $error("wrong reset value");

    // Read data is captured at setup and stands through the access
    a_rd_word: assert property (@(posedge sys_clk) disable iff (rst) // R6
        s_rd_hit |=> (prdata == {16'h0000, $past(reg_r)}))
        else $error("mapped read data wrong");
    a_rd_unmap: assert property (@(posedge sys_clk) disable iff (rst) // R6
        s_rd_miss |=> (prdata == 32'h00000000))
        else $error("unmapped read data not zero");
    a_rd_stable: assert property (@(posedge sys_clk) disable iff (rst) // R4
        !(psel && !penable && !pwrite) |=> $stable(prdata))
        else $error("read data moved outside a read setup");
    a_phase_track: assert property (@(posedge sys_clk) disable iff (rst) // R4
        (psel && penable) |-> (phase_r == IPF_ACC))
        else $error("access phase without a setup cycle");
    a_err_miss: assert property (@(posedge sys_clk) disable iff (rst) // R6
        (psel && penable && !hit) |-> pslverr)
        else $error("unmapped access not flagged");
    a_err_quiet: assert property (@(posedge sys_clk) disable iff (rst) // R6
        (psel && penable && hit) |-> !pslverr)
        else $error("mapped access flagged as error");
endmodule
`default_nettype wire

/* File: design/ipf_map.svh */
// Register map constants for the priority register slice
`ifndef IPF_MAP_SVH
`define IPF_MAP_SVH
`define IPF_REG_OFFSET 12'h000
`define IPF_CN_LSB 12
`define IPF_CMP_LSB 8
`define IPF_MST_LSB 4
`define IPF_SLV_LSB 0
`define IPF_FIELD_RESET 3'h4
`define IPF_FIELD_MASK 16'h7777
`define IPF_LVL_OFF 3'h0
`endif

/* File: design/ipf_pkg.sv */
// Types shared by the priority register slice
`default_nettype none
package ipf_pkg;
    // Source index order: slave, master, comparator, change notify
    typedef logic [2:0] ipf_level_t;
    typedef struct packed {
        logic [3:0] req;
    } ipf_src_t;
    typedef struct packed {
        logic [3:0] irq;
        ipf_level_t [3:0] level;
    } ipf_out_t;
    typedef enum logic [1:0] {
        IPF_IDLE = 2'b01,
        IPF_ACC = 2'b10
    } ipf_phase_t;
endpackage
`default_nettype wire

/* File: tb/tb_top.sv */
// Self-checking testbench for the priority register slice
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import ipf_pkg::*;
    // ==========
    // Stimulus and design
    logic sys_clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [3:0] pstrb = 4'hF;
    logic pready, pslverr, er;
    ipf_src_t src = '0;
    ipf_out_t prio;
    int bad_count = 0, checks_done = 0;
    ipf_prio_reg dut_u (.sys_clk(sys_clk), .rst(rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .src(src), .prio(prio));
    // Clock
    initial begin
        forever #5 sys_clk = ~sys_clk;
    end
    // ==========
    // Shared tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // One APB transfer; read data and error taken at the pready edge
    task automatic apb(input logic wr, input logic [11:0] a,
        input logic [31:0] d);
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do @(posedge sys_clk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge sys_clk);
    endtask
    // Drive requests, write the register, read it back
    task automatic put(input logic [3:0] r, input logic [15:0] d);
        @(posedge sys_clk);
        src <= '{req: r};
        apb(1'b1, 12'h000, {16'h0, d});
        apb(1'b0, 12'h000, 32'h0);
    endtask
    // ==========
    // Scenarios
    task automatic t_reset;
        apb(1'b0, 12'h000, 32'h0);
        chk(rd, 32'h4444);
        chk(er, 1'b0);
        chk(prio.level, 12'h924);
    endtask
    task automatic t_levels;
        put(4'hF, 16'hFFFF);
        chk(rd, 32'h7777);
        chk({prio.irq, prio.level}, 16'hFFFF);
        put(4'hF, 16'h3201);
        chk({prio.irq, prio.level}, {4'hD, 3'd3, 3'd2, 3'd0, 3'd1});
        put(4'hF, 16'h0000);
        chk(prio.irq, 4'h0);
    endtask
    task automatic t_fields;
        put(4'h6, 16'h0700);
        chk(rd, 32'h0700);
        chk({prio.irq, prio.level}, {4'h4, 3'd0, 3'd7, 3'd0, 3'd0});
        put(4'h6, 16'h0050);
        chk({rd[15:0], prio.irq}, 20'h00502);
    endtask
    // Unmapped word: flagged, ignored, reads zero
    task automatic t_unmap;
        apb(1'b1, 12'h004, 32'hFFFF);
        chk(er, 1'b1);
        apb(1'b0, 12'h004, 32'h0);
        chk(er, 1'b1);
        chk(rd, 32'h00000000);
        apb(1'b0, 12'h000, 32'h0);
        chk(rd, 32'h0050);
    endtask
    // Byte strobes: each lane writes only its own fields
    task automatic t_strobe;
        pstrb <= 4'h2;
        put(4'hF, 16'h7777);
        chk(rd, 32'h7750);
        pstrb <= 4'h1;
        put(4'hF, 16'h0000);
        chk({rd[15:0], prio.irq}, 20'h7700C);
        pstrb <= 4'hF;
    endtask
    // ==========
    // Verdict, sequence and watchdog
    task automatic finish_test;
        $display("checks %0d bad %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        repeat (12) @(posedge sys_clk);
        rst <= 1'b0;
        t_reset();
        t_levels();
        t_fields();
        t_unmap();
        t_strobe();
        finish_test();
    end
    initial begin
        #20us;
        bad_count++;
        finish_test();
    end
endmodule
`default_nettype wire
